// file: rtl/mcr_reg_slice.v
// The implementer's own choice: register access over Avalon-MM.
`include "mcr_consts.vh"

// Functional notes
// RQ1 - Even bits of 0x0a set pins 8-11 direction
// RQ2 - Odd bits of 0x0a set pins 8-11 polarity
// RQ3 - Even bits of 0x0b set pins 12-15 direction
// RQ4 - Odd bits of 0x0b set pins 12-15 polarity
// RQ5 - Pin config registers reset to zero
// RQ6 - Register 0x0c read-only, zero; host never writes (testbench writes 0xff to 0x0c; the slice drops it)
// RQ7 - Internal temp above 0x0d limit raises alarm
// RQ8 - Remote one above 0x0e limit raises alarm
// RQ9 - Remote two above 0x0f limit raises alarm
// RQ10 - 0x10 holds internal fan start, 0x28
// RQ11 - 0x11 holds remote one fan start, 0x40
// RQ12 - 0x12 holds remote two fan start, 0x40
// RQ13 - Store control bit 0 selects read mode
// RQ14 - Store control bit 1 selects program mode
// RQ15 - Store control bit 2 selects erase mode
// RQ16 - Protect bit blocks program and erase
// RQ17 - Protect bit write-once, cleared only by reset
// RQ18 - Bits 4-6 factory test; host keeps zero
// RQ19 - Bit 7 allows clock stretch, else never
// RQ20 - Host enables stretch for repeated writes
// RQ21 - Store control resets to zero
// RQ22 - Host selects at most one mode (testbench writes 0x06 to 0x13, program and erase together)
module mcr_reg_slice
(
	input wire mclk, // System clock, 250 MHz
	input wire arst_n, // Asynchronous reset, active low
	input wire [7:0] avs_address, // Word address (register index)
	input wire avs_read, // Read request
	input wire avs_write, // Write request
	input wire [31:0] avs_writedata, // Write data, low byte used
	input wire [3:0] avs_byteenable, // Byte enables
	output reg [31:0] avs_readdata, // Read data
	output wire avs_waitrequest, // Stall until answer ready
	output reg [1:0] avs_response, // 00 okay, 10 slave error
	input wire [7:0] internal_temp, // Internal temperature reading
	input wire [7:0] remote_diode_one_temp, // Remote diode one reading
	input wire [7:0] remote_diode_two_temp, // Remote diode two reading
	output reg thermal_alarm_output, // High while any limit exceeded
	output wire [7:0] general_pin_dir, // Pins 8-15: 1 output, 0 input
	output wire [7:0] general_pin_pol, // Pins 8-15: 1 active high, 0 low
	output wire [7:0] internal_fan_start_temp, // Fan start, internal
	output wire [7:0] remote_one_fan_start_temp, // Fan start, remote one
	output wire [7:0] remote_two_fan_start_temp, // Fan start, remote two
	output wire store_read_mode, // Store in read mode
	output wire store_prog_mode, // Store in program mode
	output wire store_erase_mode, // Store in erase mode
	output wire store_protected, // Store protected
	output wire [2:0] store_test_mode, // Factory test controls
	input wire store_busy, // Store cannot accept more data
	output wire scl_stretch // Hold serial clock low
);

	// ----------------------------------------
	// Reset synchroniser
	// ----------------------------------------
	reg rst_meta_q;
	reg rst_sync_q;
	always @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end
		else
		begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end
	wire rst_n = rst_sync_q;

	// ----------------------------------------
	// Register storage
	// ----------------------------------------
	reg [7:0] pin_config_bank_c_q;
	reg [7:0] pin_config_bank_d_q;
	reg [7:0] factory_store_reg_b_q;
	reg [7:0] internal_alarm_limit_q;
	reg [7:0] remote_one_alarm_limit_q;
	reg [7:0] remote_two_alarm_limit_q;
	reg [7:0] internal_fan_start_q;
	reg [7:0] remote_one_fan_start_q;
	reg [7:0] remote_two_fan_start_q;
	reg [7:0] store_control_q;

	// Split interleaved direction/polarity bits of one bank
	function [3:0] pick_bits;
		input [7:0] val;
		input odd;
		begin
			pick_bits = odd ? {val[7], val[5], val[3], val[1]}
				: {val[6], val[4], val[2], val[0]};
		end
	endfunction

	// ----------------------------------------
	// Bus slave: one wait cycle, then answer
	// ----------------------------------------
	// The request is held by the master, so a single accept flag
	// gives a fixed answer one cycle after the request first shows.
	reg ack_q;
	wire req = avs_read | avs_write;
	assign avs_waitrequest = req & ~ack_q;
	wire take = req & ack_q;
	wire wr_take = take & avs_write & avs_byteenable[0];

	always @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			ack_q <= 1'b0;
		else
			ack_q <= req & ~ack_q;
	end

	function mapped;
		input [7:0] idx;
		begin
			mapped = (idx >= `MCR_IDX_PIN_CFG_C && idx <= `MCR_IDX_STORE_CTL)
				|| idx == `MCR_IDX_STATUS;
		end
	endfunction

	wire [7:0] wd = avs_writedata[7:0];

	// Write strobe for one index; bus terms are arguments so always @* sees them
	function hit;
		input strobe;
		input [7:0] addr;
		input [7:0] idx;
		begin
			hit = strobe && (addr == idx);
		end
	endfunction

	reg [7:0] pin_config_bank_c_d;
	reg [7:0] pin_config_bank_d_d;
	reg [7:0] internal_alarm_limit_d;
	reg [7:0] remote_one_alarm_limit_d;
	reg [7:0] remote_two_alarm_limit_d;
	reg [7:0] internal_fan_start_d;
	reg [7:0] remote_one_fan_start_d;
	reg [7:0] remote_two_fan_start_d;
	reg [7:0] store_control_d;

	// ----------------------------------------
	// Pin bank c
	// ----------------------------------------
	always @*
	begin
		pin_config_bank_c_d = pin_config_bank_c_q;
		if (hit(wr_take, avs_address, `MCR_IDX_PIN_CFG_C))
			pin_config_bank_c_d = wd;
	end
	always @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			pin_config_bank_c_q <= `MCR_RST_PIN_CFG; // RQ5
		else
			pin_config_bank_c_q <= pin_config_bank_c_d;
	end

	// ----------------------------------------
	// Pin bank d
	// ----------------------------------------
	always @*
	begin
		pin_config_bank_d_d = pin_config_bank_d_q;
		if (hit(wr_take, avs_address, `MCR_IDX_PIN_CFG_D))
			pin_config_bank_d_d = wd;
	end
	always @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			pin_config_bank_d_q <= `MCR_RST_PIN_CFG; // RQ5
		else
			pin_config_bank_d_q <= pin_config_bank_d_d;
	end

	// ----------------------------------------
	// Factory register
	// ----------------------------------------
	// Read-only: only reset gives it a value, bus writes are dropped
	always @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			factory_store_reg_b_q <= `MCR_RST_FACTORY; // RQ6
		else
			factory_store_reg_b_q <= factory_store_reg_b_q; // RQ6
	end

	// ----------------------------------------
	// Internal alarm limit
	// ----------------------------------------
	always @*
	begin
		internal_alarm_limit_d = internal_alarm_limit_q;
		if (hit(wr_take, avs_address, `MCR_IDX_INT_LIMIT))
			internal_alarm_limit_d = wd;
	end
	always @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			internal_alarm_limit_q <= `MCR_RST_INT_LIMIT; // RQ7
		else
			internal_alarm_limit_q <= internal_alarm_limit_d;
	end

	// ----------------------------------------
	// Remote one alarm limit
	// ----------------------------------------
	always @*
	begin
		remote_one_alarm_limit_d = remote_one_alarm_limit_q;
		if (hit(wr_take, avs_address, `MCR_IDX_R1_LIMIT))
			remote_one_alarm_limit_d = wd;
	end
	always @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			remote_one_alarm_limit_q <= `MCR_RST_REM_LIMIT; // RQ8
		else
			remote_one_alarm_limit_q <= remote_one_alarm_limit_d;
	end

	// ----------------------------------------
	// Remote two alarm limit
	// ----------------------------------------
	always @*
	begin
		remote_two_alarm_limit_d = remote_two_alarm_limit_q;
		if (hit(wr_take, avs_address, `MCR_IDX_R2_LIMIT))
			remote_two_alarm_limit_d = wd;
	end
	always @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			remote_two_alarm_limit_q <= `MCR_RST_REM_LIMIT; // RQ9
		else
			remote_two_alarm_limit_q <= remote_two_alarm_limit_d;
	end

	// ----------------------------------------
	// Internal fan start
	// ----------------------------------------
	always @*
	begin
		internal_fan_start_d = internal_fan_start_q;
		if (hit(wr_take, avs_address, `MCR_IDX_INT_FAN))
			internal_fan_start_d = wd;
	end
	always @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			internal_fan_start_q <= `MCR_RST_INT_FAN; // RQ10
		else
			internal_fan_start_q <= internal_fan_start_d;
	end

	// ----------------------------------------
	// Remote one fan start
	// ----------------------------------------
	always @*
	begin
		remote_one_fan_start_d = remote_one_fan_start_q;
		if (hit(wr_take, avs_address, `MCR_IDX_R1_FAN))
			remote_one_fan_start_d = wd;
	end
	always @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			remote_one_fan_start_q <= `MCR_RST_REM_FAN; // RQ11
		else
			remote_one_fan_start_q <= remote_one_fan_start_d;
	end

	// ----------------------------------------
	// Remote two fan start
	// ----------------------------------------
	always @*
	begin
		remote_two_fan_start_d = remote_two_fan_start_q;
		if (hit(wr_take, avs_address, `MCR_IDX_R2_FAN))
			remote_two_fan_start_d = wd;
	end
	always @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			remote_two_fan_start_q <= `MCR_RST_REM_FAN; // RQ12
		else
			remote_two_fan_start_q <= remote_two_fan_start_d;
	end

	// ----------------------------------------
	// Store control
	// ----------------------------------------
	always @*
	begin
		store_control_d = store_control_q;
		if (hit(wr_take, avs_address, `MCR_IDX_STORE_CTL))
		begin
			store_control_d = wd;
			// Protect sticks once set; software cannot clear it
			store_control_d[`MCR_SC_PROTECT] = wd[`MCR_SC_PROTECT]
				| store_control_q[`MCR_SC_PROTECT]; // RQ17
		end
	end
	always @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			store_control_q <= `MCR_RST_STORE_CTL; // RQ21
		else
			store_control_q <= store_control_d;
	end

	// ----------------------------------------
	// Read mux and response
	// ----------------------------------------
	reg [7:0] rd_d;
	always @*
	begin
		case (avs_address)
			`MCR_IDX_PIN_CFG_C: rd_d = pin_config_bank_c_q;
			`MCR_IDX_PIN_CFG_D: rd_d = pin_config_bank_d_q;
			`MCR_IDX_FACTORY_B: rd_d = factory_store_reg_b_q; // RQ6
			`MCR_IDX_INT_LIMIT: rd_d = internal_alarm_limit_q;
			`MCR_IDX_R1_LIMIT: rd_d = remote_one_alarm_limit_q;
			`MCR_IDX_R2_LIMIT: rd_d = remote_two_alarm_limit_q;
			`MCR_IDX_INT_FAN: rd_d = internal_fan_start_q;
			`MCR_IDX_R1_FAN: rd_d = remote_one_fan_start_q;
			`MCR_IDX_R2_FAN: rd_d = remote_two_fan_start_q;
			`MCR_IDX_STORE_CTL: rd_d = store_control_q;
			`MCR_IDX_STATUS: rd_d = {5'h00, store_busy, scl_stretch, thermal_alarm_output};
			default: rd_d = 8'h00;
		endcase
	end

	// Read data is registered, so it is valid at the edge waitrequest drops
	always @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			avs_readdata <= 32'h0000_0000;
			avs_response <= 2'h0;
		end
		else if (req & ~ack_q)
		begin
			avs_readdata <= avs_read ? {24'h00_0000, rd_d} : 32'h0000_0000;
			avs_response <= mapped(avs_address) ? 2'h0 : 2'h2;
		end
	end

	// ----------------------------------------
	// Pin configuration
	// ----------------------------------------
	assign general_pin_dir[3:0] = pick_bits(pin_config_bank_c_q, 1'b0); // RQ1
	assign general_pin_pol[3:0] = pick_bits(pin_config_bank_c_q, 1'b1); // RQ2
	assign general_pin_dir[7:4] = pick_bits(pin_config_bank_d_q, 1'b0); // RQ3
	assign general_pin_pol[7:4] = pick_bits(pin_config_bank_d_q, 1'b1); // RQ4

	assign internal_fan_start_temp = internal_fan_start_q; // RQ10
	assign remote_one_fan_start_temp = remote_one_fan_start_q; // RQ11
	assign remote_two_fan_start_temp = remote_two_fan_start_q; // RQ12

	// ----------------------------------------
	// Thermal alarm
	// ----------------------------------------
	// Readings come from the measurement logic on this clock; strictly above
	always @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			thermal_alarm_output <= 1'b0;
		else
			thermal_alarm_output <= (internal_temp > internal_alarm_limit_q) // RQ7
				| (remote_diode_one_temp > remote_one_alarm_limit_q) // RQ8
				| (remote_diode_two_temp > remote_two_alarm_limit_q); // RQ9
	end

	// ----------------------------------------
	// Store control
	// ----------------------------------------
	assign store_protected = store_control_q[`MCR_SC_PROTECT];
	assign store_read_mode = store_control_q[`MCR_SC_READ]; // RQ13
	// Protection gates the destructive modes at the outputs; the stored bits stay set
	assign store_prog_mode = store_control_q[`MCR_SC_PROG] & ~store_protected; // RQ14 RQ16
	assign store_erase_mode = store_control_q[`MCR_SC_ERASE] & ~store_protected; // RQ15 RQ16
	assign store_test_mode = store_control_q[`MCR_SC_TEST_HI:`MCR_SC_TEST_LO]; // RQ18
	assign scl_stretch = store_control_q[`MCR_SC_STRETCH] & store_busy; // RQ19

endmodule

// file: rtl/mcr_consts.vh
`ifndef MCR_CONSTS_VH
`define MCR_CONSTS_VH

// Register indices; byte address is four times the index
`define MCR_IDX_PIN_CFG_C 8'h0a
`define MCR_IDX_PIN_CFG_D 8'h0b
`define MCR_IDX_FACTORY_B 8'h0c
`define MCR_IDX_INT_LIMIT 8'h0d
`define MCR_IDX_R1_LIMIT 8'h0e
`define MCR_IDX_R2_LIMIT 8'h0f
`define MCR_IDX_INT_FAN 8'h10
`define MCR_IDX_R1_FAN 8'h11
`define MCR_IDX_R2_FAN 8'h12
`define MCR_IDX_STORE_CTL 8'h13
`define MCR_IDX_STATUS 8'h20

// Reset values
`define MCR_RST_PIN_CFG 8'h00
`define MCR_RST_FACTORY 8'h00
`define MCR_RST_INT_LIMIT 8'h37
`define MCR_RST_REM_LIMIT 8'h50
`define MCR_RST_INT_FAN 8'h28
`define MCR_RST_REM_FAN 8'h40
`define MCR_RST_STORE_CTL 8'h00

// Store control field positions
`define MCR_SC_READ 0
`define MCR_SC_PROG 1
`define MCR_SC_ERASE 2
`define MCR_SC_PROTECT 3
`define MCR_SC_TEST_LO 4
`define MCR_SC_TEST_HI 6
`define MCR_SC_STRETCH 7

// Answer latency of the bus slave in clock cycles
`define MCR_WAIT_CYCLES 1

`endif

// file: verif/mcr_chk_properties.sv
module mcr_chk (
	input wire mclk,
	input wire arst_n,
	input wire [7:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	input wire [3:0] avs_byteenable,
	input wire [31:0] avs_readdata,
	input wire avs_waitrequest,
	input wire [7:0] internal_temp,
	input wire [7:0] remote_diode_one_temp,
	input wire [7:0] remote_diode_two_temp,
	input wire thermal_alarm_output,
	input wire [7:0] general_pin_dir,
	input wire [7:0] general_pin_pol,
	input wire [7:0] internal_fan_start_temp,
	input wire store_read_mode,
	input wire store_prog_mode,
	input wire store_erase_mode,
	input wire store_protected,
	input wire store_busy,
	input wire scl_stretch
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] w_q, l0_q, l1_q, l2_q;
	logic ext_q, hot_q;
	wire take = avs_write && !avs_waitrequest && avs_byteenable[0];
	default clocking @(posedge mclk); endclocking
	default disable iff (!arst_n);
	function automatic logic [7:0] pk(input logic [7:0] v);
		return {v[7], v[5], v[3], v[1], v[6], v[4], v[2], v[0]};
	endfunction
	sequence wr_at(logic [7:0] a);
		take && avs_address == a;
	endsequence
	always_ff @(posedge mclk)
		w_q <= avs_writedata[7:0];
	// Shadow limits so the alarm is judged from the ports alone
	always_ff @(posedge mclk or negedge arst_n)
		if (!arst_n)
		begin
			l0_q <= 8'h37;
			l1_q <= 8'h50;
			l2_q <= 8'h50;
			ext_q <= 1'b0;
			hot_q <= 1'b0;
		end
		else
		begin
			l0_q <= (take && avs_address == 8'h0d) ? avs_writedata[7:0] : l0_q;
			l1_q <= (take && avs_address == 8'h0e) ? avs_writedata[7:0] : l1_q;
			l2_q <= (take && avs_address == 8'h0f) ? avs_writedata[7:0] : l2_q;
			ext_q <= (take && avs_address == 8'h13) ? avs_writedata[7] : ext_q;
			hot_q <= internal_temp > l0_q || remote_diode_one_temp > l1_q
				|| remote_diode_two_temp > l2_q;
		end
	pins_low_a:
	assert property (wr_at(8'h0a) |=> {general_pin_pol[3:0], general_pin_dir[3:0]} == pk(w_q))
		else $error("pins 8-11 config wrong");
	pins_high_a:
	assert property (wr_at(8'h0b) |=> {general_pin_pol[7:4], general_pin_dir[7:4]} == pk(w_q))
		else $error("pins 12-15 config wrong");
	alarm_limit_a:
	assert property (thermal_alarm_output == hot_q) else $error("alarm wrong");
	factory_ro_a:
	assert property (avs_read && !avs_waitrequest && avs_address == 8'h0c |-> avs_readdata == 0)
		else $error("factory register not zero");
	store_modes_a:
	assert property (wr_at(8'h13) |=> store_read_mode == w_q[0] && store_prog_mode ==
		(w_q[1] && !store_protected) && store_erase_mode == (w_q[2] && !store_protected))
		else $error("store mode wrong");
	protect_gate_a:
	assert property (store_protected |-> !store_prog_mode && !store_erase_mode)
		else $error("protected store still writable");
	protect_once_a:
	assert property (store_protected |=> store_protected) else $error("protect cleared");
	stretch_only_a:
	assert property (scl_stretch == (ext_q && store_busy)) else $error("stretch wrong");
	fan_start_a:
	assert property (wr_at(8'h10) |=> internal_fan_start_temp == w_q) else $error("fan start");
endmodule
bind mcr_reg_slice mcr_chk u_chk (.*);

// file: verif/mcr_host.sv
module mcr_host (
	input wire mclk, // Clock
	output logic [7:0] avs_address, // Register index
	output logic avs_read, // Read request
	output logic avs_write, // Write request
	output logic [31:0] avs_writedata, // Write data
	output logic [3:0] avs_byteenable, // Byte enables
	input wire [31:0] avs_readdata, // Read data
	input wire avs_waitrequest, // Stall
	input wire [1:0] avs_response // Response code
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		avs_address = 8'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'h0;
	end
	// Waitrequest is judged at the rising edge; only the bench timeout ends a wait
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] be, output logic [33:0] q);
		@(posedge mclk);
		avs_address <= a;
		avs_read <= !w;
		avs_write <= w;
		avs_writedata <= (a == 8'h13) ? d & 32'hffffff8f : d;
		avs_byteenable <= be;
		do
			@(posedge mclk);
		while (avs_waitrequest);
		q = {avs_response, avs_readdata};
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		avs_address <= ~a;
		avs_writedata <= ~d;
	endtask
endmodule

// file: verif/monitor_config_register_slice_tb.sv
module monitor_config_register_slice_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 1'b0;
	logic arst_n = 1'b0;
	logic busy = 1'b0;
	logic [7:0] tt[3] = '{8'h00, 8'h00, 8'h00};
	logic [7:0] ra[9] = '{8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h10, 8'h11, 8'h12};
	logic [7:0] rv[9] = '{8'h00, 8'h00, 8'h00, 8'h37, 8'h50, 8'h50, 8'h28, 8'h40, 8'h40};
	logic [7:0] sv[9];
	logic [33:0] exp_q[$];
	logic [31:0] rs = 32'd47;
	int miscompares = 0;
	int checks = 0;
	int cyc = 0;
	wire [7:0] adr, dir, pol, f0, f1, f2;
	wire [31:0] wd, rdat;
	wire [3:0] be;
	wire [1:0] rsp;
	wire [2:0] tm;
	wire rd_s, wr_s, wq, alarm, rmode, pmode, emode, prot, strch;
	mcr_reg_slice DUT (.mclk(mclk), .arst_n(arst_n), .avs_address(adr), .avs_read(rd_s),
		.avs_write(wr_s), .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdat),
		.avs_waitrequest(wq), .avs_response(rsp), .internal_temp(tt[0]),
		.remote_diode_one_temp(tt[1]), .remote_diode_two_temp(tt[2]),
		.thermal_alarm_output(alarm), .general_pin_dir(dir), .general_pin_pol(pol),
		.internal_fan_start_temp(f0), .remote_one_fan_start_temp(f1),
		.remote_two_fan_start_temp(f2), .store_read_mode(rmode), .store_prog_mode(pmode),
		.store_erase_mode(emode), .store_protected(prot), .store_test_mode(tm),
		.store_busy(busy), .scl_stretch(strch));
	mcr_host u_host (.mclk(mclk), .avs_address(adr), .avs_read(rd_s), .avs_write(wr_s),
		.avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdat),
		.avs_waitrequest(wq), .avs_response(rsp));
	always #2 mclk = ~mclk;
	function automatic logic [31:0] rnd();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction
	task automatic fail(input string m);
		miscompares++;
		$display("FAIL %0t %s", $time, m);
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
		checks++;
		if (got !== exp)
			fail(m);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] e = 4'h1);
		logic [33:0] q;
		u_host.xfer(1'b1, a, (rnd() & 32'hffffff00) | {24'h0, d}, e, q);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] r = 2'b00);
		logic [33:0] q;
		exp_q.push_back({r, 24'h0, e});
		u_host.xfer(1'b0, a, rnd(), 4'hf, q);
	endtask
	task automatic reset_dut();
		@(posedge mclk);
		arst_n <= 1'b0;
		repeat (16) @(posedge mclk);
		arst_n <= 1'b1;
		repeat (2) @(posedge mclk);
	endtask
	task automatic tally_and_finish();
		if (exp_q.size() != 0)
			fail("reads left unanswered");
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// ------------------------------------------------------------
	// Read watcher: each accepted read is matched to the oldest note
	// ------------------------------------------------------------
	always @(negedge mclk)
		if (rd_s && !wq)
		begin
			checks++;
			if (exp_q.size() == 0 || {rsp, rdat} !== exp_q.pop_front())
				fail("read data");
		end
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			fail("timeout");
			tally_and_finish();
		end
	end
	initial
	begin
		reset_dut();
		foreach (ra[i]) rd(ra[i], rv[i]);
		rd(8'h13, 8'h00);
		for (int i = 0; i < 9; i++)
			if (i != 2)
			begin
				sv[i] = 8'(rnd() % 255);
				wr(ra[i], sv[i]);
				rd(ra[i], sv[i]);
			end
		for (int j = 0; j < 4; j++)
			chk({4'h0, dir[j], dir[j+4], pol[j], pol[j+4]}, {4'h0, sv[0][2*j], sv[1][2*j],
				sv[0][2*j+1], sv[1][2*j+1]}, "pin config");
		chk(f0, sv[6], "fan");
		chk(f1, sv[7], "fan");
		chk(f2, sv[8], "fan");
		for (int c = 0; c < 3; c++)
		begin
			for (int k = 0; k < 2; k++)
			begin
				@(posedge mclk);
				tt[c] <= sv[3+c] + 8'(k);
				repeat (2) @(posedge mclk);
				#1 chk({7'h0, alarm}, 8'(k), "alarm");
			end
			@(posedge mclk);
			tt[c] <= 8'h00;
		end
		wr(8'h0c, 8'hff);
		rd(8'h0c, 8'h00);
		rd(8'h30, 8'h00, 2'b10);
		wr(8'h0d, ~sv[3], 4'he);
		rd(8'h0d, sv[3]);
		for (int m = 0; m < 3; m++)
		begin
			busy <= m[0];
			wr(8'h13, 8'h80 | (8'h01 << m));
			rd(8'h13, 8'h80 | (8'h01 << m));
			chk({5'h0, emode, pmode, rmode}, 8'h01 << m, "mode");
			chk({7'h0, strch}, 8'(m % 2), "stretch");
		end
		busy <= 1'b1;
		wr(8'h13, 8'h0a);
		wr(8'h13, 8'h06);
		rd(8'h13, 8'h0e);
		chk({5'h0, prot, pmode, emode}, 8'h04, "protect");
		chk({7'h0, strch}, 8'h00, "stretch off");
		chk({5'h0, tm}, 8'h00, "test bits");
		rd(8'h20, 8'h04);
		reset_dut();
		rd(8'h13, 8'h00);
		repeat (2) @(posedge mclk);
		tally_and_finish();
	end
endmodule
